// ### dv/arcc_ctrl_tb_top.sv
`timescale 1ns/1ps
`include "arcc_cfg.svh"
module arcc_ctrl_tb_top
  import arcc_pkg::*;
;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        hw;
  logic        done;
  logic [9:0]  cdat;
  logic        conv_start_o;
  logic        conv_abort_o;
  logic [4:0]  channel_o;
  logic [1:0]  mode_o;
  logic        irq_o;
  int          bad_count;
  int          samples_checked;
  int          starts;
  int          aborts;
  int          s;
  int          a;

  always #2 clk_i = ~clk_i;

  arcc_ctrl dut (
    .clk_i                    (clk_i),
    .rst_i                    (rst_i),
    .wb_cyc_i                 (cyc),
    .wb_stb_i                 (stb),
    .wb_we_i                  (we),
    .wb_adr_i                 (adr),
    .wb_sel_i                 (4'hF),
    .wb_dat_i                 (wdat),
    .wb_dat_o                 (wb_dat_o),
    .wb_ack_o                 (wb_ack_o),
    .hardware_trigger_input_i (hw),
    .conv_done_i              (done),
    .conv_data_i              (cdat),
    .conv_start_o             (conv_start_o),
    .conv_abort_o             (conv_abort_o),
    .channel_o                (channel_o),
    .mode_o                   (mode_o),
    .irq_o                    (irq_o)
  );

  // pulses are one cycle wide, so count them rather than poll
  always @(posedge clk_i) begin
    if (conv_start_o === 1'b1) starts++;
    if (conv_abort_o === 1'b1) aborts++;
  end

  task automatic conclude;
    $display("bad_count=%0d samples_checked=%0d", bad_count, samples_checked);
    if (bad_count == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // classic single cycle; request held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] ad, input logic [7:0] d);
    int   n;
    logic got;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= ad;
    wdat <= {24'h000000, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 16);
    rdat = wb_dat_o;
    got = (wb_ack_o === 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    #1;
    // a missing ack ends the run here
    if (!got) begin
      bad_count++;
      conclude();
    end
  endtask

  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    wb(1'b1, ad, d);
  endtask

  task automatic rd(input logic [7:0] ad, input logic [7:0] e);
    wb(1'b0, ad, 8'h00);
    chk(rdat, {24'h000000, e});
  endtask

  // released data lines show inverted garbage, not the last value
  task automatic conv(input logic [9:0] d);
    @(posedge clk_i);
    done <= 1'b1;
    cdat <= d;
    @(posedge clk_i);
    done <= 1'b0;
    cdat <= ~d;
    @(posedge clk_i);
    #1;
  endtask

  task automatic cmp(input logic [7:0] sc2, input logic [9:0] d,
                     input logic [7:0] rl, input logic cc);
    wr(`ARCC_OFF_SC2, sc2);
    wr(`ARCC_OFF_SC1, 8'h03);
    conv(d);
    rd(`ARCC_OFF_SC1, {cc, 7'h03});
    rd(`ARCC_OFF_RL, rl);
  endtask

  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    wdat = 32'h00000000;
    hw = 1'b0;
    done = 1'b0;
    cdat = 10'h000;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`ARCC_OFF_SC2, 8'h00);
    rd(`ARCC_OFF_RL, 8'h00);
    rd(`ARCC_OFF_CVH, 8'h00);
    rd(`ARCC_OFF_CVL, 8'h00);
    rd(8'h30, 8'h00);
    chk(mode_o, 2'h0);
    wr(`ARCC_OFF_INT_EN, 8'h01);
    // software start in 8-bit mode
    wr(`ARCC_OFF_SC1, 8'h03);
    chk(starts, 1);
    rd(`ARCC_OFF_SC2, 8'h80);
    conv(10'h2A5);
    rd(`ARCC_OFF_SC2, 8'h00);
    rd(`ARCC_OFF_SC1, 8'h83);
    chk(irq_o, 1'b1);
    rd(`ARCC_OFF_RH, 8'h00);
    rd(`ARCC_OFF_RL, 8'hA5);
    rd(`ARCC_OFF_SC1, 8'h03);
    wr(`ARCC_OFF_INT_CLR, 8'h01);
    rd(`ARCC_OFF_INT_STAT, 8'h00);
    chk(irq_o, 1'b0);
    // 10-bit mode, invalidation and interlock
    wr(`ARCC_OFF_CFG, 8'h08);
    chk(mode_o, 2'h2);
    rd(`ARCC_OFF_RL, 8'h00);
    wr(`ARCC_OFF_SC1, 8'h03);
    conv(10'h2A5);
    rd(`ARCC_OFF_RH, 8'h02);
    wr(`ARCC_OFF_SC1, 8'h03);
    conv(10'h155);
    rd(`ARCC_OFF_INT_STAT, 8'h03);
    rd(`ARCC_OFF_RL, 8'hA5);
    wr(`ARCC_OFF_SC1, 8'h03);
    conv(10'h155);
    rd(`ARCC_OFF_RH, 8'h01);
    rd(`ARCC_OFF_RL, 8'h55);
    // 8-bit mode has no interlock
    wr(`ARCC_OFF_CFG, 8'h00);
    wr(`ARCC_OFF_SC1, 8'h03);
    conv(10'h0C3);
    rd(`ARCC_OFF_RH, 8'h00);
    wr(`ARCC_OFF_SC1, 8'h03);
    conv(10'h03C);
    rd(`ARCC_OFF_RL, 8'h3C);
    // compare: value 0x180 in 10-bit, 0x80 in 8-bit
    wr(`ARCC_OFF_CVL, 8'h80);
    wr(`ARCC_OFF_CVH, 8'h01);
    rd(`ARCC_OFF_CVH, 8'h01);
    cmp(8'h10, 10'h001, 8'h01, 1'b1);
    cmp(8'h20, 10'h090, 8'h01, 1'b0);
    cmp(8'h20, 10'h070, 8'h70, 1'b1);
    cmp(8'h30, 10'h080, 8'h80, 1'b1);
    cmp(8'h30, 10'h07F, 8'h80, 1'b0);
    wr(`ARCC_OFF_CFG, 8'h08);
    cmp(8'h30, 10'h0FF, 8'h00, 1'b0);
    cmp(8'h30, 10'h1A0, 8'hA0, 1'b1);
    // hardware trigger
    wr(`ARCC_OFF_SC2, 8'h40);
    rd(`ARCC_OFF_SC2, 8'h40);
    s = starts;
    @(posedge clk_i);
    hw <= 1'b1;
    repeat (3) @(posedge clk_i);
    hw <= 1'b0;
    #1;
    chk(starts, s + 1);
    rd(`ARCC_OFF_SC2, 8'hC0);
    conv(10'h002);
    rd(`ARCC_OFF_SC2, 8'h40);
    // abort and restart, then abort into the off channel
    wr(`ARCC_OFF_SC2, 8'h00);
    wr(`ARCC_OFF_SC1, 8'h03);
    s = starts;
    a = aborts;
    wr(`ARCC_OFF_SC1, 8'h05);
    chk(aborts, a + 1);
    chk(starts, s + 1);
    chk(channel_o, 5'h05);
    wr(`ARCC_OFF_SC1, 8'h1F);
    chk(aborts, a + 2);
    chk(starts, s + 1);
    rd(`ARCC_OFF_SC2, 8'h00);
    // masked interrupt still latches status
    wr(`ARCC_OFF_INT_CLR, 8'h07);
    wr(`ARCC_OFF_INT_EN, 8'h00);
    wr(`ARCC_OFF_SC1, 8'h03);
    conv(10'h011);
    rd(`ARCC_OFF_INT_STAT, 8'h01);
    chk(irq_o, 1'b0);
    wr(`ARCC_OFF_INT_EN, 8'h01);
    rd(`ARCC_OFF_INT_EN, 8'h01);
    chk(irq_o, 1'b1);
    conclude();
  end
endmodule

// ### verilog/arcc_cfg.svh
`ifndef ARCC_CFG_SVH
`define ARCC_CFG_SVH

// register byte offsets on the wishbone bus
`define ARCC_OFF_SC1      8'h00
`define ARCC_OFF_SC2      8'h04
`define ARCC_OFF_RH       8'h08
`define ARCC_OFF_RL       8'h0C
`define ARCC_OFF_CVH      8'h10
`define ARCC_OFF_CVL      8'h14
`define ARCC_OFF_CFG      8'h18
`define ARCC_OFF_INT_STAT 8'h1C
`define ARCC_OFF_INT_CLR  8'h20
`define ARCC_OFF_INT_EN   8'h24

// status_control_one fields
`define ARCC_SC1_CC_BIT   7
`define ARCC_SC1_CH_LO    0
// status_control_two fields
`define ARCC_SC2_ACT_BIT  7
`define ARCC_SC2_TRG_BIT  6
`define ARCC_SC2_CFE_BIT  5
`define ARCC_SC2_CGE_BIT  4
// configuration fields
`define ARCC_CFG_MODE_LO  2

// encodings
`define ARCC_CH_OFF       5'h1F
`define ARCC_MODE_8BIT    2'h0
`define ARCC_MODE_10BIT   2'h2

// interrupt status bits
`define ARCC_INT_DONE_BIT 0
`define ARCC_INT_LOST_BIT 1
`define ARCC_INT_ABRT_BIT 2

// reset values
`define ARCC_RST_CH       5'h00
`define ARCC_RST_MODE     2'h0
`define ARCC_RST_BYTE     8'h00
`define ARCC_RST_RES      10'h000
`define ARCC_RST_INT      3'h0

`endif

// ### verilog/arcc_ctrl.sv
// Our own choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
`include "arcc_cfg.svh"

module arcc_ctrl
  import arcc_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // converter core
  input  wire logic        hardware_trigger_input_i,
  input  wire logic        conv_done_i,
  input  wire logic [9:0]  conv_data_i,
  output logic             conv_start_o,
  output logic             conv_abort_o,
  output logic      [4:0]  channel_o,
  output logic      [1:0]  mode_o,
  // interrupt
  output logic             irq_o
);

  arcc_state_t state_ff,    nxt_state;
  arcc_ctl_t   ctl_ff,      nxt_ctl;
  arcc_res_t   res_ff,      nxt_res;
  logic        cc_ff,       nxt_cc;
  logic        hw_prev_ff,  nxt_hw_prev;
  logic        start_ff,    nxt_start;
  logic        abort_ff,    nxt_abort;
  logic [2:0]  int_stat_ff, nxt_int_stat;
  logic [2:0]  int_en_ff,   nxt_int_en;
  logic        irq_ff,      nxt_irq;
  logic        ack_ff,      nxt_ack;
  logic [31:0] dat_ff,      nxt_dat;

  logic        acc;
  logic        wr;
  logic        rd;
  logic        wr_sc1;
  logic        rd_rh;
  logic        rd_rl;
  logic        is10;
  logic        hw_edge;
  logic        ch_on;
  logic        start_req;
  logic        done_ok;
  logic [9:0]  res_new;
  logic [9:0]  cmp_val;
  logic        cmp_true;
  logic        load_ok;
  logic        mode_chg;
  logic [1:0]  wr_mode;
  logic [2:0]  ev;

  // bus decode: one access per request, ack drops the cycle after
  assign acc    = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign wr     = acc & wb_we_i & wb_sel_i[0];
  assign rd     = acc & ~wb_we_i;
  assign wr_sc1 = wr & (wb_adr_i == `ARCC_OFF_SC1);
  assign rd_rh  = rd & (wb_adr_i == `ARCC_OFF_RH);
  assign rd_rl  = rd & (wb_adr_i == `ARCC_OFF_RL);

  assign is10    = (ctl_ff.mode == `ARCC_MODE_10BIT);
  assign hw_edge = hardware_trigger_input_i & ~hw_prev_ff;
  assign ch_on   = (ctl_ff.ch != `ARCC_CH_OFF);

  // a write to control one in software trigger mode restarts with the channel just written, unless that channel is off
  always_comb begin
    if (wr_sc1) begin
      start_req = ~ctl_ff.trg & (wb_dat_i[`ARCC_SC1_CH_LO +: 5] != `ARCC_CH_OFF);
    end else begin
      start_req = ctl_ff.trg & hw_edge & ch_on & (state_ff == ARCC_IDLE);
    end
  end

  // completion in the same cycle as an abort is dropped
  assign done_ok = conv_done_i & (state_ff == ARCC_BUSY) & ~wr_sc1;

  // 8-bit results keep the top bits at zero
  assign res_new = is10 ? conv_data_i : {2'h0, conv_data_i[7:0]};
  assign cmp_val = is10 ? {ctl_ff.cvh, ctl_ff.cvl} : {2'h0, ctl_ff.cvl};
  assign cmp_true = ctl_ff.cge ? (res_new >= cmp_val) : (res_new < cmp_val);
  assign load_ok  = done_ok & (~ctl_ff.cfe | cmp_true) & ~res_ff.lock;

  assign wr_mode  = wb_dat_i[`ARCC_CFG_MODE_LO +: 2];
  assign mode_chg = wr & (wb_adr_i == `ARCC_OFF_CFG) & (wr_mode != ctl_ff.mode);

  // conversion sequencing
  always_comb begin
    nxt_state   = state_ff;
    nxt_start   = 1'b0;
    nxt_abort   = 1'b0;
    nxt_hw_prev = hardware_trigger_input_i;
    if (wr_sc1 && state_ff == ARCC_BUSY) begin
      nxt_abort = 1'b1;
      nxt_state = ARCC_IDLE;
    end else if (done_ok) begin
      nxt_state = ARCC_IDLE;
    end
    if (start_req) begin
      nxt_start = 1'b1;
      nxt_state = ARCC_BUSY;
    end
    case (state_ff)
      ARCC_IDLE: ;
      ARCC_BUSY: ;
      default:   nxt_state = ARCC_IDLE;
    endcase
  end

  // control registers
  always_comb begin
    nxt_ctl = ctl_ff;
    if (wr) begin
      case (wb_adr_i)
        `ARCC_OFF_SC1: nxt_ctl.ch = wb_dat_i[`ARCC_SC1_CH_LO +: 5];
        `ARCC_OFF_SC2: begin
          // reserved low bits are simply not stored
          nxt_ctl.trg = wb_dat_i[`ARCC_SC2_TRG_BIT];
          nxt_ctl.cfe = wb_dat_i[`ARCC_SC2_CFE_BIT];
          nxt_ctl.cge = wb_dat_i[`ARCC_SC2_CGE_BIT];
        end
        `ARCC_OFF_CVH: nxt_ctl.cvh = wb_dat_i[1:0];
        `ARCC_OFF_CVL: nxt_ctl.cvl = wb_dat_i[7:0];
        `ARCC_OFF_CFG: nxt_ctl.mode = wr_mode;
        default:       nxt_ctl = ctl_ff;
      endcase
    end
  end

  // result registers and interlock
  always_comb begin
    nxt_res = res_ff;
    if (rd_rh && is10 && !rd_rl) begin
      nxt_res.lock = 1'b1;
    end
    if (rd_rl || !is10) begin
      nxt_res.lock = 1'b0;
    end
    if (load_ok) begin
      nxt_res.data  = res_new;
      nxt_res.valid = 1'b1;
    end
    if (mode_chg) begin
      nxt_res.valid = 1'b0;
      nxt_res.lock  = 1'b0;
    end
  end

  // complete flag: a set in the clearing cycle wins
  always_comb begin
    nxt_cc = cc_ff;
    if (wr_sc1 || rd_rl) begin
      nxt_cc = 1'b0;
    end
    if (load_ok) begin
      nxt_cc = 1'b1;
    end
  end

  // interrupt status, enable and level output
  always_comb begin
    ev                      = 3'h0;
    ev[`ARCC_INT_DONE_BIT]  = load_ok;
    ev[`ARCC_INT_LOST_BIT]  = done_ok & res_ff.lock;
    ev[`ARCC_INT_ABRT_BIT]  = wr_sc1 & (state_ff == ARCC_BUSY);
    nxt_int_stat = int_stat_ff;
    nxt_int_en   = int_en_ff;
    if (wr && wb_adr_i == `ARCC_OFF_INT_CLR) begin
      nxt_int_stat = int_stat_ff & ~wb_dat_i[2:0];
    end
    if (wr && wb_adr_i == `ARCC_OFF_INT_EN) begin
      nxt_int_en = wb_dat_i[2:0];
    end
    nxt_int_stat = nxt_int_stat | ev;
    nxt_irq      = |(nxt_int_stat & nxt_int_en);
  end

  // read data; invalid results read as zero
  always_comb begin
    nxt_ack = acc;
    nxt_dat = 32'h0;
    if (rd) begin
      case (wb_adr_i)
        `ARCC_OFF_SC1: begin
          nxt_dat[`ARCC_SC1_CC_BIT]        = cc_ff;
          nxt_dat[`ARCC_SC1_CH_LO +: 5]    = ctl_ff.ch;
        end
        `ARCC_OFF_SC2: begin
          nxt_dat[`ARCC_SC2_ACT_BIT] = (state_ff == ARCC_BUSY);
          nxt_dat[`ARCC_SC2_TRG_BIT] = ctl_ff.trg;
          nxt_dat[`ARCC_SC2_CFE_BIT] = ctl_ff.cfe;
          nxt_dat[`ARCC_SC2_CGE_BIT] = ctl_ff.cge;
        end
        `ARCC_OFF_RH: begin
          nxt_dat[1:0] = (res_ff.valid && is10) ? res_ff.data[9:8] : 2'h0;
        end
        `ARCC_OFF_RL: begin
          nxt_dat[7:0] = res_ff.valid ? res_ff.data[7:0] : 8'h00;
        end
        `ARCC_OFF_CVH:      nxt_dat[1:0] = ctl_ff.cvh;
        `ARCC_OFF_CVL:      nxt_dat[7:0] = ctl_ff.cvl;
        `ARCC_OFF_CFG:      nxt_dat[`ARCC_CFG_MODE_LO +: 2] = ctl_ff.mode;
        `ARCC_OFF_INT_STAT: nxt_dat[2:0] = int_stat_ff;
        `ARCC_OFF_INT_EN:   nxt_dat[2:0] = int_en_ff;
        default:            nxt_dat = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff    <= ARCC_IDLE;
      ctl_ff      <= '{trg: 1'b0, cfe: 1'b0, cge: 1'b0, ch: `ARCC_RST_CH,
                       mode: `ARCC_RST_MODE, cvh: 2'h0, cvl: `ARCC_RST_BYTE};
      res_ff      <= '{valid: 1'b0, lock: 1'b0, data: `ARCC_RST_RES};
      cc_ff       <= 1'b0;
      hw_prev_ff  <= 1'b0;
      start_ff    <= 1'b0;
      abort_ff    <= 1'b0;
      int_stat_ff <= `ARCC_RST_INT;
      int_en_ff   <= `ARCC_RST_INT;
      irq_ff      <= 1'b0;
      ack_ff      <= 1'b0;
      dat_ff      <= 32'h0;
    end else begin
      state_ff    <= nxt_state;
      ctl_ff      <= nxt_ctl;
      res_ff      <= nxt_res;
      cc_ff       <= nxt_cc;
      hw_prev_ff  <= nxt_hw_prev;
      start_ff    <= nxt_start;
      abort_ff    <= nxt_abort;
      int_stat_ff <= nxt_int_stat;
      int_en_ff   <= nxt_int_en;
      irq_ff      <= nxt_irq;
      ack_ff      <= nxt_ack;
      dat_ff      <= nxt_dat;
    end
  end

  assign wb_dat_o     = dat_ff;
  assign wb_ack_o     = ack_ff;
  assign conv_start_o = start_ff;
  assign conv_abort_o = abort_ff;
  assign channel_o    = ctl_ff.ch;
  assign mode_o       = ctl_ff.mode;
  assign irq_o        = irq_ff;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_active_on_start: assert property (
    start_req |=> (state_ff == ARCC_BUSY) && conv_start_o)
    else $error("active flag not set on start");

  a_active_clear: assert property (
    (done_ok && !start_req) |=> state_ff == ARCC_IDLE)
    else $error("active flag not cleared on completion");

  a_sw_trig_start: assert property (
    (wr_sc1 && !ctl_ff.trg && wb_dat_i[`ARCC_SC1_CH_LO +: 5] != `ARCC_CH_OFF) |=> conv_start_o)
    else $error("software write did not start conversion");

  a_hw_trig_ignored: assert property (
    (!ctl_ff.trg && !wr_sc1) |=> !conv_start_o)
    else $error("hardware trigger started in software mode");

  a_abort_restart: assert property (
    (wr_sc1 && state_ff == ARCC_BUSY) |=> conv_abort_o)
    else $error("write did not abort running conversion");

  a_cmp_skip_load: assert property (
    (done_ok && ctl_ff.cfe && !cmp_true) |=> $stable(res_ff.data))
    else $error("result loaded on false compare");

  a_lock_discard: assert property (
    (res_ff.lock && done_ok) |=> $stable(res_ff.data) && int_stat_ff[`ARCC_INT_LOST_BIT])
    else $error("result loaded while interlocked");

  a_lock_set: assert property (
    (rd_rh && is10 && !mode_chg) |=> res_ff.lock [*1] ##0 !rd_rl[*1])
    else $error("interlock not taken on high read");

  a_no_lock_8bit: assert property (
    !is10 |=> !res_ff.lock || is10)
    else $error("interlock held in 8-bit mode");

  a_mode_invalid: assert property (
    mode_chg |=> !res_ff.valid)
    else $error("result still valid after mode change");

  a_cc_set: assert property (
    load_ok |=> cc_ff)
    else $error("complete flag not set on load");

  a_cc_clear: assert property (
    (rd_rl && !load_ok) |=> !cc_ff)
    else $error("complete flag not cleared by low read");

  a_rh_8bit_zero: assert property (
    (rd_rh && !is10) |=> wb_dat_o[1:0] == 2'h0)
    else $error("high result nonzero in 8-bit mode");

  a_ack_one_cycle: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  a_cfe_off_load: assert property (
    (done_ok && !ctl_ff.cfe && !res_ff.lock) |=> cc_ff)
    else $error("completion not flagged with compare off");

  a_cmp_less_8bit: assert property (
    (done_ok && ctl_ff.cfe && !ctl_ff.cge && !is10 && (conv_data_i[7:0] < ctl_ff.cvl))
    |=> cc_ff)
    else $error("true less-than compare not flagged");

  a_cmp_ge_10bit: assert property (
    (done_ok && ctl_ff.cfe && ctl_ff.cge && is10 && !res_ff.lock
     && (conv_data_i >= {ctl_ff.cvh, ctl_ff.cvl})) |=> cc_ff)
    else $error("true 10-bit compare not flagged");

  a_cmp_low_only: assert property (
    (done_ok && ctl_ff.cfe && ctl_ff.cge && !is10 && (conv_data_i[7:0] >= ctl_ff.cvl))
    |=> cc_ff)
    else $error("8-bit compare did not use low byte only");

  a_rl_load_data: assert property (
    load_ok |=> res_ff.data[7:0] == $past(conv_data_i[7:0]))
    else $error("low result byte not taken from converter");

  a_rh_load_data: assert property (
    (load_ok && is10) |=> res_ff.data[9:8] == $past(conv_data_i[9:8]))
    else $error("high result bits not taken from converter");

  a_mode_decode: assert property (
    (rd_rh && ctl_ff.mode != `ARCC_MODE_10BIT) |=> wb_dat_o[1:0] == 2'h0)
    else $error("non 10-bit mode shows high result bits");

  a_stat_set_wins: assert property (
    (ev != 3'h0) |=> (int_stat_ff & $past(ev)) == $past(ev))
    else $error("status event lost to a same-cycle clear");

  a_irq_level: assert property (
    irq_o == |(int_stat_ff & int_en_ff))
    else $error("interrupt level disagrees with enabled status");

  a_reset_zero: assert property (
    $fell(rst_i) |-> (ctl_ff == '0) && !conv_start_o && !irq_o)
    else $error("control state not zero after reset");

endmodule

// ### verilog/arcc_pkg.sv
package arcc_pkg;

  typedef enum logic {
    ARCC_IDLE,
    ARCC_BUSY
  } arcc_state_t;

  // software-written control state
  typedef struct packed {
    logic       trg;
    logic       cfe;
    logic       cge;
    logic [4:0] ch;
    logic [1:0] mode;
    logic [1:0] cvh;
    logic [7:0] cvl;
  } arcc_ctl_t;

  // result holding state
  typedef struct packed {
    logic       valid;
    logic       lock;
    logic [9:0] data;
  } arcc_res_t;

endpackage
